// >>> logic/pin_input_filter.sv
// three-flop pad synchroniser with agreement filter
module pin_input_filter
	import port_b_mux_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic pad_i,
	output logic level_o
);

	logic [SYNC_STAGES-1:0] sync_r;  // shift chain, bit 0 is first flop
	logic [SYNC_STAGES-1:0] sync_nxt;
	logic level_r;  // accepted level
	logic level_nxt;

	// next values: first flop is read only by the second
	always_comb begin
		sync_nxt = {sync_r[SYNC_STAGES-2:0], pad_i};
		level_nxt = level_r;
		// a change counts only once stages two and three agree
		if (sync_r[1] == sync_r[2]) begin
			level_nxt = sync_r[2];
		end
	end

	// registers only
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			sync_r <= {SYNC_STAGES{RST_PIN_LEVEL}};
			level_r <= RST_PIN_LEVEL;
		end else begin
			sync_r <= sync_nxt;
			level_r <= level_nxt;
		end
	end

	assign level_o = level_r;

endmodule

// >>> logic/port_b_mux_pkg.sv
package port_b_mux_pkg;

	// pin function select codes, as set by the system integration module
	localparam logic [1:0] FUNC_GPIO = 2'h0;
	localparam logic [1:0] FUNC_SERIAL = 2'h1;
	localparam logic [1:0] FUNC_TIMER = 2'h2;
	localparam logic [1:0] FUNC_PWM_SRC = 2'h3;

	// pin index inside the two-pin arrays
	localparam int PIN_TWO = 0;
	localparam int PIN_THREE = 1;
	localparam int PIN_COUNT = 2;

	// reset values
	localparam logic RST_PIN_LEVEL = 1'h1;  // pulled-up pad reads high
	localparam logic RST_OUT_LEVEL = 1'h0;
	localparam logic RST_PULLUP = 1'h1;
	localparam logic RST_OE = 1'h0;
	localparam logic INACTIVE_LEVEL = 1'h0;  // seen by unselected inputs

	// input filter depth: three flip-flops, last two must agree
	localparam int SYNC_STAGES = 3;

endpackage

// >>> logic/port_b_pin_function_mux.sv
module port_b_pin_function_mux
	import port_b_mux_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// configuration from the system integration module
	input wire logic [1:0] port_b_pin_two_sel_i,
	input wire logic [1:0] port_b_pin_three_sel_i,
	// gpio controller
	input wire logic [PIN_COUNT-1:0] gpio_dir_out_i,
	input wire logic [PIN_COUNT-1:0] gpio_data_out_i,
	output logic [PIN_COUNT-1:0] gpio_data_in_o,
	// queued_serial_port_zero
	input wire logic serial0_master_mode_i,
	input wire logic serial0_slave_sel_n_i,
	input wire logic serial0_launch_i,
	input wire logic serial0_tx_bit_i,
	output logic serial0_master_in_line_o,
	output logic serial0_master_out_line_o,
	// timer_a channels two and three
	input wire logic [PIN_COUNT-1:0] timer_chan_out_i,
	input wire logic [PIN_COUNT-1:0] timer_chan_oe_i,
	output logic timer_a_channel_two_o,
	output logic timer_a_channel_three_o,
	// external pwm sources
	output logic pwm_pair45_source_in_o,
	output logic pwm_pair23_source_in_o,
	// pads: port_b_pin_two is index 0, port_b_pin_three index 1
	input wire logic [PIN_COUNT-1:0] pad_in_i,
	output logic [PIN_COUNT-1:0] pad_out_o,
	output logic [PIN_COUNT-1:0] pad_oe_o,
	output logic [PIN_COUNT-1:0] pad_pullup_o
);

	logic [PIN_COUNT-1:0] pad_lvl;  // filtered pad levels
	logic [1:0] sel [PIN_COUNT];  // per-pin function select

	assign sel[PIN_TWO] = port_b_pin_two_sel_i;
	assign sel[PIN_THREE] = port_b_pin_three_sel_i;

	// one filter per pad
	for (genvar g = 0; g < PIN_COUNT; g++) begin : g_filt
		pin_input_filter u_filt (
			.clk_sys_i(clk_sys_i),
			.rst_n_i(rst_n_i),
			.pad_i(pad_in_i[g]),
			.level_o(pad_lvl[g])
		);
	end

	// serial data launch holder
	logic tx_bit_r;
	logic tx_bit_nxt;

	// bit changes only on the launch edge, so it stands a half
	// serial clock before the opposite (sampling) edge
	always_comb begin
		tx_bit_nxt = tx_bit_r;
		if (serial0_launch_i) begin
			tx_bit_nxt = serial0_tx_bit_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			tx_bit_r <= RST_OUT_LEVEL;
		end else begin
			tx_bit_r <= tx_bit_nxt;
		end
	end

	// pad drive state
	logic [PIN_COUNT-1:0] out_r, out_nxt;
	logic [PIN_COUNT-1:0] oe_r, oe_nxt;
	logic [PIN_COUNT-1:0] pu_r, pu_nxt;
	// direction a pin takes in serial mode: pin two carries master-in,
	// pin three master-out
	logic [PIN_COUNT-1:0] ser_drive;

	always_comb begin
		// slave output only while selected, else high impedance
		ser_drive[PIN_TWO] = !serial0_master_mode_i &&
			!serial0_slave_sel_n_i;
		ser_drive[PIN_THREE] = serial0_master_mode_i;
	end

	// next pad drive values
	always_comb begin
		out_nxt = {PIN_COUNT{RST_OUT_LEVEL}};
		oe_nxt = {PIN_COUNT{RST_OE}};
		for (int i = 0; i < PIN_COUNT; i++) begin
			unique case (sel[i])
				FUNC_GPIO: begin
					oe_nxt[i] = gpio_dir_out_i[i];
					out_nxt[i] = gpio_data_out_i[i];
				end
				FUNC_SERIAL: begin
					oe_nxt[i] = ser_drive[i];
					out_nxt[i] = tx_bit_nxt;
				end
				FUNC_TIMER: begin
					oe_nxt[i] = timer_chan_oe_i[i];
					out_nxt[i] = timer_chan_out_i[i];
				end
				FUNC_PWM_SRC: begin
					oe_nxt[i] = RST_OE;  // input only
				end
			endcase
		end
		// pull-up holds an undriven pad at a known level
		pu_nxt = ~oe_nxt;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			out_r <= {PIN_COUNT{RST_OUT_LEVEL}};
			oe_r <= {PIN_COUNT{RST_OE}};
			pu_r <= {PIN_COUNT{RST_PULLUP}};
		end else begin
			out_r <= out_nxt;
			oe_r <= oe_nxt;
			pu_r <= pu_nxt;
		end
	end

	// peripheral-side inputs
	logic [PIN_COUNT-1:0] gpio_in_r, gpio_in_nxt;
	logic [PIN_COUNT-1:0] tmr_in_r, tmr_in_nxt;
	logic [PIN_COUNT-1:0] pwm_r, pwm_nxt;
	logic miso_r, miso_nxt;
	logic mosi_r, mosi_nxt;

	// route each filtered pad to the one selected receiver only
	always_comb begin
		gpio_in_nxt = {PIN_COUNT{INACTIVE_LEVEL}};
		tmr_in_nxt = {PIN_COUNT{INACTIVE_LEVEL}};
		pwm_nxt = {PIN_COUNT{INACTIVE_LEVEL}};
		for (int i = 0; i < PIN_COUNT; i++) begin
			unique case (sel[i])
				FUNC_GPIO: gpio_in_nxt[i] = pad_lvl[i];
				FUNC_TIMER: tmr_in_nxt[i] = pad_lvl[i];
				FUNC_PWM_SRC: pwm_nxt[i] = pad_lvl[i];
				FUNC_SERIAL: begin
				end
			endcase
		end
		// serial receive: master listens on pin two, slave on pin three
		miso_nxt = INACTIVE_LEVEL;
		mosi_nxt = INACTIVE_LEVEL;
		if (sel[PIN_TWO] == FUNC_SERIAL && serial0_master_mode_i) begin
			miso_nxt = pad_lvl[PIN_TWO];
		end
		if (sel[PIN_THREE] == FUNC_SERIAL && !serial0_master_mode_i) begin
			mosi_nxt = pad_lvl[PIN_THREE];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			gpio_in_r <= {PIN_COUNT{RST_PIN_LEVEL}};
			tmr_in_r <= {PIN_COUNT{INACTIVE_LEVEL}};
			pwm_r <= {PIN_COUNT{INACTIVE_LEVEL}};
			miso_r <= INACTIVE_LEVEL;
			mosi_r <= INACTIVE_LEVEL;
		end else begin
			gpio_in_r <= gpio_in_nxt;
			tmr_in_r <= tmr_in_nxt;
			pwm_r <= pwm_nxt;
			miso_r <= miso_nxt;
			mosi_r <= mosi_nxt;
		end
	end

	assign pad_out_o = out_r;
	assign pad_oe_o = oe_r;
	assign pad_pullup_o = pu_r;
	assign gpio_data_in_o = gpio_in_r;
	assign timer_a_channel_two_o = tmr_in_r[PIN_TWO];
	assign timer_a_channel_three_o = tmr_in_r[PIN_THREE];
	assign pwm_pair45_source_in_o = pwm_r[PIN_TWO];
	assign pwm_pair23_source_in_o = pwm_r[PIN_THREE];
	assign serial0_master_in_line_o = miso_r;
	assign serial0_master_out_line_o = mosi_r;

	// checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	property p_reset_gpio;
		@(posedge clk_sys_i) disable iff (1'b0)
		!rst_n_i |=> (pad_oe_o == 2'h0 && pad_pullup_o == 2'h3);
	endproperty
	a_reset_gpio: assert property (p_reset_gpio)
		else $error("reset left a pad driven or unpulled");

	property p_gpio_out;
		(port_b_pin_three_sel_i == FUNC_GPIO && gpio_dir_out_i[1]) |=>
			(pad_oe_o[1] && pad_out_o[1] == $past(gpio_data_out_i[1]));
	endproperty
	a_gpio_out: assert property (p_gpio_out)
		else $error("gpio output not driven on pin three");

	property p_gpio_in;
		(port_b_pin_two_sel_i == FUNC_GPIO && !gpio_dir_out_i[0]) |=>
			(!pad_oe_o[0] && pad_pullup_o[0]);
	endproperty
	a_gpio_in: assert property (p_gpio_in)
		else $error("gpio input pin two is driven");

	property p_pwm_no_drive;
		(port_b_pin_two_sel_i == FUNC_PWM_SRC) ##1
			(port_b_pin_two_sel_i == FUNC_PWM_SRC) |=> !pad_oe_o[0];
	endproperty
	a_pwm_no_drive: assert property (p_pwm_no_drive)
		else $error("pwm source pin is driven");

	property p_miso_hiz;
		(port_b_pin_two_sel_i == FUNC_SERIAL && !serial0_master_mode_i &&
			serial0_slave_sel_n_i) |=> !pad_oe_o[0];
	endproperty
	a_miso_hiz: assert property (p_miso_hiz)
		else $error("unselected slave drives master-in line");

	property p_launch_only;
		!serial0_launch_i |=> $stable(tx_bit_r);
	endproperty
	a_launch_only: assert property (p_launch_only)
		else $error("serial bit changed without launch");

	property p_mosi_drive;
		(port_b_pin_three_sel_i == FUNC_SERIAL && serial0_master_mode_i)
			|=> (pad_oe_o[1] && pad_out_o[1] == tx_bit_r);
	endproperty
	a_mosi_drive: assert property (p_mosi_drive)
		else $error("master-out line not carrying launched bit");

	property p_pwm45;
		(port_b_pin_two_sel_i == FUNC_PWM_SRC) |=>
			(pwm_pair45_source_in_o == $past(pad_lvl[0]));
	endproperty
	a_pwm45: assert property (p_pwm45)
		else $error("pair 4/5 source does not follow pin two");

	property p_pwm23;
		(port_b_pin_three_sel_i == FUNC_PWM_SRC) |=>
			(pwm_pair23_source_in_o == $past(pad_lvl[1]));
	endproperty
	a_pwm23: assert property (p_pwm23)
		else $error("pair 2/3 source does not follow pin three");

	property p_exclusive;
		(port_b_pin_two_sel_i != FUNC_TIMER &&
			port_b_pin_two_sel_i != FUNC_PWM_SRC) |=>
			(!timer_a_channel_two_o && !pwm_pair45_source_in_o);
	endproperty
	a_exclusive: assert property (p_exclusive)
		else $error("unselected function sees pin two");

	c_gpio_out: cover property (port_b_pin_two_sel_i == FUNC_GPIO &&
		gpio_dir_out_i[0] ##1 pad_oe_o[0]);
	c_slave_tx: cover property (!serial0_master_mode_i &&
		!serial0_slave_sel_n_i && port_b_pin_two_sel_i == FUNC_SERIAL
		##1 pad_oe_o[0]);
	c_pwm_src: cover property (pwm_pair23_source_in_o ##1
		!pwm_pair23_source_in_o);

endmodule

// >>> verif/pad_partner.sv
// far side of the two pads: external serial device and line drivers
module pad_partner
	import port_b_mux_pkg::*;
(
	input wire logic [PIN_COUNT-1:0] pad_out_i,
	input wire logic [PIN_COUNT-1:0] pad_oe_i,
	input wire logic [PIN_COUNT-1:0] pad_pullup_i,
	input wire logic [PIN_COUNT-1:0] ext_en_i,
	input wire logic [PIN_COUNT-1:0] ext_val_i,
	output logic [PIN_COUNT-1:0] pad_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// resolved wire: device drive wins, then far side, then pull-up
	always_comb begin
		for (int k = 0; k < PIN_COUNT; k++) begin
			if (pad_oe_i[k])
				pad_o[k] = pad_out_i[k];
			else if (ext_en_i[k])
				pad_o[k] = ext_val_i[k];
			else if (pad_pullup_i[k])
				pad_o[k] = 1'h1;
			else
				pad_o[k] = ~pad_out_i[k]; // floating: never the old value
		end
	end
endmodule

// >>> verif/port_b_pin_function_mux_tb_top.sv
module port_b_pin_function_mux_tb_top;
	import port_b_mux_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk_sys_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic [1:0] sel2 = 2'h0, sel3 = 2'h0, dir = 2'h0, dout = 2'h0;
	logic mode = 1'h0, ss_n = 1'h1, launch = 1'h0, tx = 1'h0;
	logic [1:0] t_out = 2'h0, t_oe = 2'h0, ext_en = 2'h0, ext_val = 2'h0;
	logic [1:0] din, pad_in, pad_out, pad_oe, pad_pu;
	logic miso, mosi, ta2, ta3, p45, p23;
	int err_count = 0;
	int compares = 0;

	always #10 clk_sys_i = ~clk_sys_i;

	port_b_pin_function_mux i_port_b_pin_function_mux (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.port_b_pin_two_sel_i(sel2), .port_b_pin_three_sel_i(sel3),
		.gpio_dir_out_i(dir), .gpio_data_out_i(dout), .gpio_data_in_o(din),
		.serial0_master_mode_i(mode), .serial0_slave_sel_n_i(ss_n),
		.serial0_launch_i(launch), .serial0_tx_bit_i(tx),
		.serial0_master_in_line_o(miso), .serial0_master_out_line_o(mosi),
		.timer_chan_out_i(t_out), .timer_chan_oe_i(t_oe),
		.timer_a_channel_two_o(ta2), .timer_a_channel_three_o(ta3),
		.pwm_pair45_source_in_o(p45), .pwm_pair23_source_in_o(p23),
		.pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
		.pad_pullup_o(pad_pu));

	pad_partner i_pad_partner (.pad_out_i(pad_out), .pad_oe_i(pad_oe),
		.pad_pullup_i(pad_pu), .ext_en_i(ext_en), .ext_val_i(ext_val),
		.pad_o(pad_in));

	// one comparison, counted; four-state so unknown never matches
	task automatic chk(input logic [1:0] got, input logic [1:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %b exp %b", $time, got, exp);
		end
	endtask

	// inputs move 2 ns after the edge, away from sampling
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#2;
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// after reset: inputs, pulled up, nothing driving
	task automatic t_reset();
		chk(pad_oe, 2'h0);
		chk(pad_pu, 2'h3);
		chk(din, {2{RST_PIN_LEVEL}});
		chk({miso, mosi} | {p45, p23}, 2'h0);
	endtask

	// each pin its own direction; far side reads back
	task automatic t_gpio();
		dir = 2'h1; dout = 2'h1; ext_en = 2'h2; ext_val = 2'h0;
		step(1);
		chk(pad_oe, 2'h1);
		chk({pad_pu[1], pad_out[0]}, 2'h3);
		step(4);
		chk(din, 2'h1);
		dir = 2'h2; dout = 2'h2; ext_en = 2'h1;
		// pin two lets go one edge late: 3 sync + level + register
		step(6);
		chk(pad_oe, 2'h2);
		chk(pad_out, 2'h2);
		chk(din, 2'h2);
	endtask

	// pwm source on both pins, gpio wanting to drive meanwhile
	task automatic t_pwm();
		sel2 = FUNC_PWM_SRC; sel3 = FUNC_PWM_SRC; dir = 2'h3;
		ext_en = 2'h3; ext_val = 2'h1;
		// pin three only floats after the edge that drops its drive
		step(6);
		chk({p45, p23}, 2'h2);
		chk(pad_oe, 2'h0);
		chk(din | {ta2, ta3}, 2'h0);
		ext_val = 2'h2;
		step(5);
		chk({p45, p23}, 2'h1);
		dir = 2'h0;
	endtask

	// timer drives pin two, pin three receives
	task automatic t_timer();
		sel2 = FUNC_TIMER; sel3 = FUNC_TIMER; t_oe = 2'h1; t_out = 2'h1;
		ext_en = 2'h2; ext_val = 2'h2;
		step(1);
		chk(pad_oe, 2'h1);
		chk(pad_out, 2'h1);
		step(4);
		chk({ta2, ta3}, 2'h3);
		chk({p45, p23}, 2'h0);
		t_oe = 2'h0;
	endtask

	// master then slave; bit held only from a launch pulse
	task automatic t_serial();
		sel2 = FUNC_SERIAL; sel3 = FUNC_SERIAL; mode = 1'h1;
		ext_en = 2'h1; ext_val = 2'h1; tx = 1'h1; launch = 1'h1;
		step(1);
		launch = 1'h0; tx = 1'h0;
		chk({pad_oe[1], pad_out[1]}, 2'h3);
		step(4);
		chk({pad_out[1], miso}, 2'h3);
		mode = 1'h0; ss_n = 1'h0; ext_en = 2'h2; ext_val = 2'h2;
		tx = 1'h1; launch = 1'h1;
		step(1);
		launch = 1'h0;
		chk(pad_oe, 2'h1);
		chk({1'h0, pad_out[0]}, 2'h1);
		step(4);
		chk({miso, mosi}, 2'h1);
		ss_n = 1'h1;
		step(1);
		chk(pad_oe, 2'h0);
	endtask

	// guard against a hang anywhere in the sequence
	initial begin
		#200000;
		err_count++;
		summarize();
	end

	initial begin
		step(3);
		rst_n_i = 1'h1;
		step(1);
		t_reset();
		t_gpio();
		t_pwm();
		t_timer();
		t_serial();
		summarize();
	end
endmodule
